// ### design/scad_map.vh
// Register map, field layout and timing constants of the aperture delay block
`ifndef SCAD_MAP_VH
`define SCAD_MAP_VH

`define SCAD_ADDR_W 12
`define SCAD_DATA_W 24
`define SCAD_OFS_EN 12'h02b0
`define SCAD_OFS_CFG 12'h02b1
`define SCAD_OFS_RESULT 12'h02b2
`define SCAD_OFS_ADJUST 12'h02b5
`define SCAD_CFG_RESET 8'h05
`define SCAD_EN_BIT 0
`define SCAD_CFG_HDUR_LSB 0
`define SCAD_CFG_AVG_LSB 2
`define SCAD_DONE_BIT 17
`define SCAD_TAD_W 17
`define SCAD_INV_BIT 16
`define SCAD_COARSE_MSB 15
`define SCAD_COARSE_LSB 8
`define SCAD_FINE_MSB 7
`define SCAD_FINE_LSB 0
`define SCAD_MAXPER_0 16'h0080
`define SCAD_MAXPER_1 16'h0680
`define SCAD_MAXPER_2 16'h1e80
`define SCAD_MAXPER_3 16'h7e80
`define SCAD_SETTLE_CYC 384
`define SCAD_CNT_W 17

`endif

// ### design/scad_aperture_ctrl.v
// SYSREF calibration engine and manual aperture delay control
`timescale 1ns/1ps
`include "scad_map.vh"

// Summary of operation
// - Accumulation code selects 4/16/64/256 cycles
// - Codes allow SYSREF periods 128..32384 cycles
// - Too long SYSREF period fails calibration
// - Longer accumulation lengthens run, reduces spread
// - Calibration ends within documented cycle bound
// - Done bit only when enabled and complete
// - Result bits return computed delay word
// - Word: bit16 invert, 15:8 coarse, 7:0 fine
// - Adjust bit 16 inverts sampling clock
// - Manual coarse delay when calibration disabled
// - Manual fine delay, any value, only when calibration disabled
// - Enable rising edge starts; manual register ignored
// - Averaging code selects 4/16/64/256 averages
module scad_aperture_ctrl #(
  parameter SETTLE_CYC = `SCAD_SETTLE_CYC
) (
  input wire ref_clk_i, // Sample clock domain clock
  input wire rst_i, // Asynchronous reset, active high
  input wire reg_wr_i, // Register write strobe
  input wire [`SCAD_ADDR_W-1:0] reg_addr_i, // Register address
  input wire [`SCAD_DATA_W-1:0] reg_wdata_i, // Register write data
  input wire sysref_i, // SYSREF timing reference
  input wire phase_late_i, // Phase detector: SYSREF sampled late
  output reg [`SCAD_DATA_W-1:0] reg_rdata_o, // Read data for reg_addr_i
  output reg [`SCAD_TAD_W-1:0] tad_o, // Applied invert, coarse, fine delay
  output reg auto_align_complete_o, // Calibration finished
  output reg cal_failed_o // SYSREF period too long
);

  // ********************************************************
  // States and helpers
  // ********************************************************
  localparam ST_IDLE = 3'd0;
  localparam ST_SETTLE = 3'd1;
  localparam ST_ACCUM = 3'd2;
  localparam ST_DONE = 3'd3;
  localparam ST_FAIL = 3'd4;

  // 4 << (2*code): 4, 16, 64, 256
  function [8:0] scad_len;
    input [1:0] code;
    begin
      scad_len = 9'h004 << {code, 1'b0};
    end
  endfunction

  function [15:0] scad_max_period;
    input [1:0] code;
    begin
      case (code)
        2'd0: scad_max_period = `SCAD_MAXPER_0;
        2'd1: scad_max_period = `SCAD_MAXPER_1;
        2'd2: scad_max_period = `SCAD_MAXPER_2;
        default: scad_max_period = `SCAD_MAXPER_3;
      endcase
    end
  endfunction

  // ********************************************************
  // Registers
  // ********************************************************
  reg auto_align_enable;
  reg [7:0] cal_config;
  reg [`SCAD_TAD_W-1:0] clock_delay_adjust;
  reg [`SCAD_TAD_W-1:0] computed_delay_word;
  reg enable_q;
  reg sysref_q;
  reg [2:0] state;
  reg [4:0] bit_idx;
  reg [`SCAD_TAD_W-1:0] trial;
  reg [15:0] settle_cnt;
  reg [8:0] hdur_cnt;
  reg [8:0] avg_cnt;
  reg [`SCAD_CNT_W-1:0] late_cnt;
  reg [`SCAD_CNT_W-1:0] total_cnt;
  reg [15:0] period_cnt;
  reg seen_edge;

  wire [1:0] accum_length_sel = cal_config[`SCAD_CFG_HDUR_LSB+1:`SCAD_CFG_HDUR_LSB];
  wire [1:0] averaging_sel = cal_config[`SCAD_CFG_AVG_LSB+1:`SCAD_CFG_AVG_LSB];
  wire [8:0] hdur_len = scad_len(accum_length_sel);
  wire [8:0] avg_len = scad_len(averaging_sel);
  wire [15:0] max_period = scad_max_period(accum_length_sel);
  wire start = auto_align_enable & ~enable_q;
  wire sysref_rise = sysref_i & ~sysref_q;
  // No reference edge for a whole supported period: the run is lost
  wire period_over = !sysref_rise && (period_cnt >= max_period);
  wire result_done = auto_align_enable && (state == ST_DONE);
  // Majority vote: late more than half of the samples means too much delay
  wire too_late = ({late_cnt, 1'b0} > {1'b0, total_cnt});
  wire [`SCAD_TAD_W-1:0] bit_mask = {{(`SCAD_TAD_W-1){1'b0}}, 1'b1} << bit_idx;

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      auto_align_enable <= 1'b0;
      cal_config <= `SCAD_CFG_RESET;
      clock_delay_adjust <= {`SCAD_TAD_W{1'b0}};
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `SCAD_OFS_EN: auto_align_enable <= reg_wdata_i[`SCAD_EN_BIT];
        `SCAD_OFS_CFG: cal_config <= {4'h0, reg_wdata_i[3:0]};
        `SCAD_OFS_ADJUST: clock_delay_adjust <= reg_wdata_i[`SCAD_TAD_W-1:0];
        default: ;
      endcase
    end
  end

  // ********************************************************
  // Calibration sequencer
  // ********************************************************
  // Successive approximation from the inversion bit down to the last fine bit.
  // Each trial settles, then votes over averages x accumulation cycles, so a
  // larger setting costs time but shrinks the spread of the result.
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_q <= 1'b0;
      sysref_q <= 1'b0;
      state <= ST_IDLE;
      bit_idx <= 5'd0;
      trial <= {`SCAD_TAD_W{1'b0}};
      computed_delay_word <= {`SCAD_TAD_W{1'b0}};
      settle_cnt <= 16'h0000;
      hdur_cnt <= 9'h000;
      avg_cnt <= 9'h000;
      late_cnt <= {`SCAD_CNT_W{1'b0}};
      total_cnt <= {`SCAD_CNT_W{1'b0}};
      period_cnt <= 16'h0000;
      seen_edge <= 1'b0;
    end else begin
      enable_q <= auto_align_enable;
      sysref_q <= sysref_i;
      if (!auto_align_enable) begin
        state <= ST_IDLE;
      end else if (start) begin
        state <= ST_SETTLE;
        bit_idx <= 5'd16;
        trial <= {1'b1, {(`SCAD_TAD_W-1){1'b0}}};
        settle_cnt <= 16'h0000;
        period_cnt <= 16'h0000;
        seen_edge <= 1'b0;
      end else begin
        if (state == ST_SETTLE || state == ST_ACCUM) begin
          if (sysref_rise) begin
            period_cnt <= 16'h0000;
            seen_edge <= 1'b1;
          end else begin
            period_cnt <= period_cnt + 16'h0001;
          end
          // Period check runs across the whole sequence
          if (period_over) begin
            state <= ST_FAIL;
          end
        end
        case (state)
          ST_SETTLE: begin
            if (!period_over) begin
              if (settle_cnt == SETTLE_CYC[15:0] - 16'h0001) begin
                state <= ST_ACCUM;
                hdur_cnt <= 9'h000;
                avg_cnt <= 9'h000;
                late_cnt <= {`SCAD_CNT_W{1'b0}};
                total_cnt <= {`SCAD_CNT_W{1'b0}};
              end else begin
                settle_cnt <= settle_cnt + 16'h0001;
              end
            end
          end
          ST_ACCUM: begin
            if (!period_over) begin
              total_cnt <= total_cnt + {{(`SCAD_CNT_W-1){1'b0}}, 1'b1};
              late_cnt <= late_cnt + {{(`SCAD_CNT_W-1){1'b0}}, phase_late_i};
              if (hdur_cnt == hdur_len - 9'h001) begin
                hdur_cnt <= 9'h000;
                if (avg_cnt == avg_len - 9'h001) begin
                  // Vote decides the bit
                  if (too_late) begin
                    trial <= (trial & ~bit_mask) | (bit_mask >> 1);
                  end else begin
                    trial <= trial | (bit_mask >> 1);
                  end
                  if (bit_idx == 5'd0) begin
                    computed_delay_word <= too_late ? (trial & ~bit_mask) : trial;
                    state <= ST_DONE;
                  end else begin
                    bit_idx <= bit_idx - 5'd1;
                    settle_cnt <= 16'h0000;
                    state <= ST_SETTLE;
                  end
                end else begin
                  avg_cnt <= avg_cnt + 9'h001;
                end
              end else begin
                hdur_cnt <= hdur_cnt + 9'h001;
              end
            end
          end
          ST_DONE: state <= ST_DONE;
          ST_FAIL: state <= ST_FAIL;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  // Manual fine bits pass straight through only while calibration is disabled; the fine stage is glitch free by design
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tad_o <= {`SCAD_TAD_W{1'b0}};
    end else if (auto_align_enable) begin
      // Manual register ignored while enabled
      if (state == ST_DONE) begin
        tad_o <= computed_delay_word;
      end else begin
        tad_o <= trial;
      end
    end else begin
      // Inversion and coarse steps are not policed; the host keeps the limits
      tad_o <= clock_delay_adjust;
    end
  end

  // ********************************************************
  // Status flags
  // ********************************************************
  // Both flags drop in the start cycle so a restart never shows a stale result
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      auto_align_complete_o <= 1'b0;
      cal_failed_o <= 1'b0;
    end else if (!auto_align_enable || start) begin
      auto_align_complete_o <= 1'b0;
      cal_failed_o <= 1'b0;
    end else begin
      auto_align_complete_o <= (state == ST_DONE);
      cal_failed_o <= (state == ST_FAIL);
    end
  end

  // ********************************************************
  // Read data
  // ********************************************************
  // Unmapped addresses read zero; reserved bits are padded with zeros
  function [`SCAD_DATA_W-1:0] scad_read;
    input [`SCAD_ADDR_W-1:0] addr;
    input en;
    input [7:0] cfg;
    input done;
    input [`SCAD_TAD_W-1:0] word;
    input [`SCAD_TAD_W-1:0] adjust;
    begin
      case (addr)
        `SCAD_OFS_EN: scad_read = {{(`SCAD_DATA_W-1){1'b0}}, en};
        `SCAD_OFS_CFG: scad_read = {{(`SCAD_DATA_W-8){1'b0}}, cfg};
        `SCAD_OFS_RESULT: scad_read = {{(`SCAD_DATA_W-`SCAD_TAD_W-1){1'b0}}, done, word};
        `SCAD_OFS_ADJUST: scad_read = {{(`SCAD_DATA_W-`SCAD_TAD_W){1'b0}}, adjust};
        default: scad_read = {`SCAD_DATA_W{1'b0}};
      endcase
    end
  endfunction

  // Registered so the read port never shows a combinational glitch
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= {`SCAD_DATA_W{1'b0}};
    end else begin
      reg_rdata_o <= scad_read(reg_addr_i, auto_align_enable, cal_config, result_done,
        computed_delay_word, clock_delay_adjust);
    end
  end

endmodule

// ### test/scad_aperture_ctrl_assertions.sv
// Port assertions for the aperture delay control block
`timescale 1ns/1ps
`include "scad_map.vh"
module scad_checker #(
  parameter SETTLE_CYC = 384
) (
  input wire ref_clk_i, // Clock
  input wire rst_i, // Reset
  input wire reg_wr_i, // Write strobe
  input wire [11:0] reg_addr_i, // Address
  input wire [23:0] reg_wdata_i, // Write data
  input wire sysref_i, // Reference
  input wire phase_late_i, // Phase detector
  input wire [23:0] reg_rdata_o, // Read data
  input wire [16:0] tad_o, // Applied delay
  input wire auto_align_complete_o, // Done
  input wire cal_failed_o // Failed
);
  // ********
  // Shadow of enable and config
  // ********
  reg en_q;
  reg [3:0] cfg_q;
  reg [39:0] run_cnt;
  wire en_wr = reg_wr_i && reg_addr_i == `SCAD_OFS_EN;
  // Bound grows by four per code step of either field
  wire [39:0] bound = 40'h0001_c800 << ((4'h0 + cfg_q[3:2] + cfg_q[1:0]) * 2);
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      cfg_q <= 4'h5;
      run_cnt <= 40'h00_0000_0000;
    end else begin
      if (en_wr)
        en_q <= reg_wdata_i[0];
      if (reg_wr_i && reg_addr_i == `SCAD_OFS_CFG)
        cfg_q <= reg_wdata_i[3:0];
      if (!en_q || auto_align_complete_o || cal_failed_o)
        run_cnt <= 40'h00_0000_0000;
      else
        run_cnt <= run_cnt + 40'h00_0000_0001;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_done_bit;
    $past(reg_addr_i) == `SCAD_OFS_RESULT && $past(auto_align_complete_o)
      && auto_align_complete_o |-> reg_rdata_o[17];
  endproperty
  a_done_bit: assert property (p_done_bit) else $error("done bit not read");
  property p_resv;
    $past(reg_addr_i) == `SCAD_OFS_RESULT |-> reg_rdata_o[23:18] == 6'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved status bits set");
  property p_unmapped;
    !($past(reg_addr_i) inside {12'h02b0, 12'h02b1, 12'h02b2, 12'h02b5})
      |-> reg_rdata_o == 24'h00_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_manual;
    (reg_wr_i && reg_addr_i == `SCAD_OFS_ADJUST && !en_q) ##1 !reg_wr_i
      |-> ##1 tad_o == $past(reg_wdata_i[16:0], 2);
  endproperty
  a_manual: assert property (p_manual) else $error("manual delay not applied");
  property p_off;
    !en_q && !$past(en_q) |-> !auto_align_complete_o && !cal_failed_o;
  endproperty
  a_off: assert property (p_off) else $error("status high while disabled");
  property p_restart;
    en_wr && reg_wdata_i[0] && !en_q |-> ##2 !auto_align_complete_o && !cal_failed_o;
  endproperty
  a_restart: assert property (p_restart) else $error("status kept on restart");
  property p_excl;
    !(auto_align_complete_o && cal_failed_o);
  endproperty
  a_excl: assert property (p_excl) else $error("done and failed together");
  property p_bound;
    run_cnt <= bound;
  endproperty
  a_bound: assert property (p_bound) else $error("calibration too long");
endmodule

bind scad_aperture_ctrl scad_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .sysref_i(sysref_i), .phase_late_i(phase_late_i),
  .reg_rdata_o(reg_rdata_o), .tad_o(tad_o), .auto_align_complete_o(auto_align_complete_o),
  .cal_failed_o(cal_failed_o));

// ### test/scad_aperture_ctrl_tb.sv
// Self-checking bench for the aperture delay control block
`timescale 1ns/1ps
module scad_aperture_ctrl_tb;
  reg ref_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg reg_wr_i = 1'b0;
  reg [11:0] reg_addr_i = 12'h0000;
  reg [23:0] reg_wdata_i = 24'h00_0000;
  reg sysref_i = 1'b0;
  reg phase_late_i = 1'b0;
  reg sr_on = 1'b1;
  wire [23:0] rdata;
  wire [16:0] tad;
  wire done;
  wire fail;
  integer errors = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer sr_cnt = 0;
  integer n;
  integer n0;
  scad_aperture_ctrl #(.SETTLE_CYC(4)) uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .sysref_i(sysref_i), .phase_late_i(phase_late_i),
    .reg_rdata_o(rdata), .tad_o(tad), .auto_align_complete_o(done), .cal_failed_o(fail));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  // Reference pulse every 64 cycles, well inside the shortest window
  always @(posedge ref_clk_i) begin
    #1;
    sr_cnt = (sr_cnt + 1) % 64;
    sysref_i = sr_on && sr_cnt == 0;
    cyc = cyc + 1;
    if (cyc == 30000) begin
      errors = errors + 1;
      stop_test;
    end
  end
  // ********
  // Access and compare tasks
  // ********
  task stop_test;
    begin
      if (errors == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [63:0] name, input [23:0] exp, input [23:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("Error %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task wr(input [11:0] a, input [23:0] d);
    begin
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      #10;
      reg_wr_i = 1'b0;
      // One idle edge between writes keeps the strobe a single pulse
      #10;
    end
  endtask
  task rchk(input [11:0] a, input [23:0] exp);
    begin
      reg_addr_i = a;
      #20;
      chk("rdata", exp, rdata);
    end
  endtask
  task run_cal(input [7:0] cfg, output integer cnt);
    begin
      wr(12'h02b1, {16'h0000, cfg});
      wr(12'h02b0, 24'h00_0001);
      cnt = 0;
      while (done !== 1'b1 && fail !== 1'b1 && cnt < 6000) begin
        #10;
        cnt = cnt + 1;
      end
    end
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    rchk(12'h02b1, 24'h00_0005);
    rchk(12'h02b5, 24'h00_0000);
    rchk(12'h02b3, 24'h00_0000);
    wr(12'h02b5, 24'hff_ffff);
    rchk(12'h02b5, 24'h01_ffff);
    chk("tad", 24'h01_ffff, {7'h00, tad});
    wr(12'h02b5, 24'h00_a55a);
    rchk(12'h02b5, 24'h00_a55a);
    chk("tad", 24'h00_a55a, {7'h00, tad});
    wr(12'h02b2, 24'hff_ffff);
    rchk(12'h02b2, 24'h00_0000);
    run_cal(8'h00, n0);
    chk("done", 24'h00_0001, {23'h00_0000, done});
    rchk(12'h02b2, 24'h03_ffff);
    chk("tad", 24'h01_ffff, {7'h00, tad});
    wr(12'h02b5, 24'h00_1234);
    rchk(12'h02b5, 24'h00_1234);
    chk("tad", 24'h01_ffff, {7'h00, tad});
    wr(12'h02b0, 24'h00_0000);
    rchk(12'h02b5, 24'h00_1234);
    chk("done", 24'h00_0000, {23'h00_0000, done});
    chk("tad", 24'h00_1234, {7'h00, tad});
    phase_late_i = 1'b1;
    run_cal(8'h01, n);
    rchk(12'h02b2, 24'h02_0000);
    chk("longer", 24'h00_0001, {23'h00_0000, n > n0});
    wr(12'h02b0, 24'h00_0000);
    sr_on = 1'b0;
    run_cal(8'h00, n);
    chk("fail", 24'h00_0001, {23'h00_0000, fail});
    chk("window", 24'h00_0001, {23'h00_0000, n >= 125 && n <= 135});
    stop_test;
  end
endmodule
